// File: shared/servo_seq_pkg.sv
// Shared constants and types for the servo enable sequencer and its host.
package servo_seq_pkg;
    localparam int CmdWidth = 32;
    localparam logic [CmdWidth-1:0] CmdZero = 32'h0000_0000;
    // Direction parameter value that keeps the command polarity.
    localparam logic DirKeep = 1'h0;
    // Cycles held in each step of the enable sequence (100 ns each).
    localparam int StepTimeNs = 1000;
    localparam int ClkPeriodNs = 100;
    localparam int StepCycles = (StepTimeNs + ClkPeriodNs - 1) / ClkPeriodNs;
    localparam int StepCntWidth = 4;
    localparam logic [StepCntWidth-1:0] StepLast = StepCntWidth'(StepCycles - 1);
    localparam logic [StepCntWidth-1:0] StepZero = 4'h0;
    localparam logic [StepCntWidth-1:0] StepOne = 4'h1;

    // Enable sequence states, one-hot.
    typedef enum logic [6:0] {
        SeqNotReady = 7'h01,
        SeqReady = 7'h02,
        SeqBrakeOff = 7'h04,
        SeqPowerOn = 7'h08,
        SeqHoldRel = 7'h10,
        SeqStatus = 7'h20,
        SeqRunning = 7'h40
    } seq_state_e;
endpackage

// File: shared/servo_link_if.sv
// Link between the host motion controller and the servo drive sequencer.
`timescale 1ns/10ps
interface servo_link_if;
    logic servoEnableRequest;
    logic cmdValid;
    logic [servo_seq_pkg::CmdWidth-1:0] cmdValue;
    logic commPolarityObject;
    logic driveReady;
    logic servoEnabledStatus;
    logic cmdAccept;
    logic motorMoving;

    modport drive (
        input servoEnableRequest,
        input cmdValid,
        input cmdValue,
        input commPolarityObject,
        output driveReady,
        output servoEnabledStatus,
        output cmdAccept,
        output motorMoving
    );
    modport host (
        output servoEnableRequest,
        output cmdValid,
        output cmdValue,
        output commPolarityObject,
        input driveReady,
        input servoEnabledStatus,
        input cmdAccept,
        input motorMoving
    );
endinterface // servo_link_if

// File: core/servo_enable_sequencer.sv
// Drive-side enable sequencer with command polarity handling.
`timescale 1ns/10ps
// Contract
// - Direction parameter value 1 reverses rotation.
// - Value 0 keeps command polarity unchanged.
// - Ready only after init and main power.
// - Enabled status set; commands still rejected then.
// - Ready display, then status; operable without alarm.
// - Host disables drive before trial jog.
// - Host sends enable before motion commands.
// - Host applies holding brake only when stopped.
// - Host disables only after motor stops; a drop of driveReady disables it at once.
module servo_enable_sequencer (
    input wire logic core_clk,
    input wire logic rst,
    servo_link_if.drive link,
    input wire logic cpuInitDone,
    input wire logic mainPowerOn,
    input wire logic alarmActive,
    input wire logic directionInvertParam,
    output logic dynamicBrakeActive,
    output logic motorPowerOn,
    output logic holdingBrakeRelease,
    output logic panelReadyMsg,
    output logic panelStatusDisplay,
    output logic operable,
    output logic [servo_seq_pkg::CmdWidth-1:0] motorCmd,
    output logic motorCmdValid
);
    servo_seq_pkg::seq_state_e state_q, state_d;
    logic [servo_seq_pkg::StepCntWidth-1:0] stepCnt_q, stepCnt_d;
    logic [servo_seq_pkg::CmdWidth-1:0] motorCmd_q;
    logic motorCmdValid_q;
    logic directionLatched_q;
    logic paramCaptured_q;
    logic shownReady_q;
    logic [2:0] initSync_q, powerSync_q, reqSync_q, alarmSync_q;
    logic initOk, powerOk, reqOk, alarmOn, stepDone, invert, takeCmd;
    logic [servo_seq_pkg::CmdWidth-1:0] cmdSigned;

    // Pins from outside pass three flops; a rise counts once stages two and three agree, a fall once stage two sees it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            initSync_q <= 3'h0;
            powerSync_q <= 3'h0;
            reqSync_q <= 3'h0;
            alarmSync_q <= 3'h0;
        end else begin
            initSync_q <= {initSync_q[1:0], cpuInitDone};
            powerSync_q <= {powerSync_q[1:0], mainPowerOn};
            reqSync_q <= {reqSync_q[1:0], link.servoEnableRequest};
            alarmSync_q <= {alarmSync_q[1:0], alarmActive};
        end
    end

    // The parameter takes effect after restart, so it is sampled once after reset release.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            directionLatched_q <= servo_seq_pkg::DirKeep;
            paramCaptured_q <= 1'h0;
        end else if (!paramCaptured_q) begin
            directionLatched_q <= directionInvertParam;
            paramCaptured_q <= 1'h1;
        end
    end

    // Held levels only; a one-cycle high glitch on stage one is never seen here, a one-cycle low glitch is.
    assign initOk = initSync_q[2] & initSync_q[1];
    assign powerOk = powerSync_q[2] & powerSync_q[1];
    assign reqOk = reqSync_q[2] & reqSync_q[1];
    // An alarm counts once both late stages see it, so a single-cycle spike is ignored.
    assign alarmOn = alarmSync_q[2] & alarmSync_q[1];
    assign stepDone = (stepCnt_q == servo_seq_pkg::StepLast);
    // Local parameter wins; the polarity object counts only when it is zero.
    assign invert = (directionLatched_q != servo_seq_pkg::DirKeep) ? 1'h1
        : link.commPolarityObject;
    assign cmdSigned = invert ? (servo_seq_pkg::CmdZero - link.cmdValue) : link.cmdValue;
    // Commands pass only in the running state, never in the first status cycle.
    assign takeCmd = (state_q == servo_seq_pkg::SeqRunning) & link.cmdValid;

    // Sequence: ready, then each actuator step held for a fixed time.
    always_comb begin
        state_d = state_q;
        stepCnt_d = stepDone ? stepCnt_q : stepCnt_q + servo_seq_pkg::StepOne;
        if (alarmOn || !initOk || !powerOk) begin
            state_d = servo_seq_pkg::SeqNotReady;
            stepCnt_d = servo_seq_pkg::StepZero;
        end else begin
            case (state_q)
                servo_seq_pkg::SeqNotReady: begin
                    state_d = servo_seq_pkg::SeqReady;
                end
                servo_seq_pkg::SeqReady: begin
                    if (reqOk) begin
                        state_d = servo_seq_pkg::SeqBrakeOff;
                        stepCnt_d = servo_seq_pkg::StepZero;
                    end
                end
                servo_seq_pkg::SeqBrakeOff: begin
                    if (stepDone) begin
                        state_d = servo_seq_pkg::SeqPowerOn;
                        stepCnt_d = servo_seq_pkg::StepZero;
                    end
                end
                servo_seq_pkg::SeqPowerOn: begin
                    if (stepDone) begin
                        state_d = servo_seq_pkg::SeqHoldRel;
                        stepCnt_d = servo_seq_pkg::StepZero;
                    end
                end
                servo_seq_pkg::SeqHoldRel: begin
                    if (stepDone) begin
                        state_d = servo_seq_pkg::SeqStatus;
                    end
                end
                servo_seq_pkg::SeqStatus: begin
                    state_d = servo_seq_pkg::SeqRunning;
                end
                servo_seq_pkg::SeqRunning: begin
                    state_d = servo_seq_pkg::SeqRunning;
                end
                default: begin
                    state_d = servo_seq_pkg::SeqNotReady;
                end
            endcase
            // Dropping the request unwinds the whole sequence back to ready.
            if (!reqOk && state_q != servo_seq_pkg::SeqNotReady) begin
                state_d = servo_seq_pkg::SeqReady;
            end
        end
    end

    // State, step counter, panel memory and the registered command path.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= servo_seq_pkg::SeqNotReady;
            stepCnt_q <= servo_seq_pkg::StepZero;
            shownReady_q <= 1'h0;
            motorCmd_q <= servo_seq_pkg::CmdZero;
            motorCmdValid_q <= 1'h0;
        end else begin
            state_q <= state_d;
            stepCnt_q <= stepCnt_d;
            shownReady_q <= shownReady_q | (state_q != servo_seq_pkg::SeqNotReady);
            motorCmdValid_q <= takeCmd;
            if (takeCmd) begin
                motorCmd_q <= cmdSigned;
            end
        end
    end

    // Outputs decoded from the state, the command registers and the panel memory; brake stays applied until the first step.
    assign link.driveReady = (state_q != servo_seq_pkg::SeqNotReady);
    assign link.servoEnabledStatus = (state_q == servo_seq_pkg::SeqStatus)
        | (state_q == servo_seq_pkg::SeqRunning);
    assign link.cmdAccept = takeCmd;
    assign link.motorMoving = motorCmdValid_q & (motorCmd_q != servo_seq_pkg::CmdZero);
    assign dynamicBrakeActive = (state_q == servo_seq_pkg::SeqNotReady)
        | (state_q == servo_seq_pkg::SeqReady);
    assign motorPowerOn = (state_q == servo_seq_pkg::SeqPowerOn)
        | (state_q == servo_seq_pkg::SeqHoldRel) | link.servoEnabledStatus;
    assign holdingBrakeRelease = (state_q == servo_seq_pkg::SeqHoldRel)
        | link.servoEnabledStatus;
    // The ready message shows until the cycle after the drive first becomes ready, then the status view.
    assign panelReadyMsg = !shownReady_q;
    assign panelStatusDisplay = shownReady_q;
    assign operable = link.driveReady & !alarmOn;
    assign motorCmd = motorCmd_q;
    assign motorCmdValid = motorCmdValid_q;
endmodule // servo_enable_sequencer

// File: core/servo_host_ctrl.sv
// Host motion controller end: enables the drive, then issues motion commands.
`timescale 1ns/10ps
module servo_host_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    servo_link_if.host link,
    input wire logic userEnable,
    input wire logic userJogStart,
    input wire logic userCmdValid,
    input wire logic [servo_seq_pkg::CmdWidth-1:0] userCmd,
    input wire logic userPolarity,
    output logic holdingBrakeApply,
    output logic jogAllowed,
    output logic cmdTaken
);
    logic enableReq_q;
    logic cmdValid_q;
    logic [servo_seq_pkg::CmdWidth-1:0] cmdValue_q;
    logic polarity_q;
    logic wantOff, stopped;

    // The host never drops enable for the user while the motor still turns; a drop of driveReady clears it at once.
    assign stopped = !link.motorMoving;
    assign wantOff = !userEnable || userJogStart;

    // Enable first; commands only once enabled status is seen.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enableReq_q <= 1'h0;
            cmdValid_q <= 1'h0;
            cmdValue_q <= servo_seq_pkg::CmdZero;
            polarity_q <= 1'h0;
        end else begin
            polarity_q <= userPolarity;
            if (wantOff) begin
                cmdValid_q <= 1'h0;
                cmdValue_q <= servo_seq_pkg::CmdZero;
                if (stopped) begin
                    enableReq_q <= 1'h0;
                end
            end else begin
                enableReq_q <= link.driveReady;
                cmdValid_q <= userCmdValid & link.servoEnabledStatus;
                cmdValue_q <= userCmd;
            end
        end
    end

    assign link.servoEnableRequest = enableReq_q;
    assign link.cmdValid = cmdValid_q;
    assign link.cmdValue = cmdValue_q;
    assign link.commPolarityObject = polarity_q;
    // Brake only when stationary and jog only while disabled.
    assign holdingBrakeApply = !enableReq_q & stopped;
    assign jogAllowed = !enableReq_q & !link.servoEnabledStatus;
    assign cmdTaken = link.cmdAccept;
endmodule // servo_host_ctrl

// File: bench/servo_link_properties.sv
// Timing checks on the link between the host end and the drive end.
`timescale 1ns/10ps
module servo_link_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic servoEnableRequest,
    input wire logic cmdValid,
    input wire logic driveReady,
    input wire logic servoEnabledStatus,
    input wire logic cmdAccept,
    input wire logic motorMoving
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Commands are taken only while enabled, and never on the first enabled cycle.
    chk_accept_needs_status: assert property (cmdAccept |-> servoEnabledStatus && cmdValid)
        else $error("accept seen without status and valid");
    chk_first_status_refuse: assert property ($rose(servoEnabledStatus) |-> !cmdAccept)
        else $error("command taken as status rose");
    chk_running_accepts: assert property (servoEnabledStatus && $past(servoEnabledStatus)
        && cmdValid |-> cmdAccept)
        else $error("command refused while running");
    // Status only comes after the three timed steps, which need 30 cycles of request.
    chk_status_after_steps: assert property ($rose(servoEnabledStatus)
        |-> $past(servoEnableRequest, 30))
        else $error("status rose too early");
    chk_request_drops_status: assert property (!servoEnableRequest [*6] |=> !servoEnabledStatus)
        else $error("status held without request");
    // Host side ordering keeps commands behind the enable handshake.
    chk_request_after_ready: assert property ($rose(servoEnableRequest) |-> $past(driveReady))
        else $error("request raised before ready");
    chk_cmd_after_status: assert property (cmdValid |-> $past(servoEnabledStatus))
        else $error("command sent before status");
    chk_drop_when_still: assert property ($fell(servoEnableRequest) |-> !$past(motorMoving))
        else $error("request dropped while moving");
endmodule // servo_link_properties

// File: bench/servo_enable_sequencer_bench.sv
// Self-checking bench joining host and drive ends over the link.
`timescale 1ns/10ps
module servo_enable_sequencer_bench;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic cpuInitDone = 1'h0, mainPowerOn = 1'h0, alarmActive = 1'h0, dirParam = 1'h0;
    logic userEnable = 1'h0, userCmdValid = 1'h0, userPolarity = 1'h0;
    logic [31:0] userCmd = 32'h0;
    logic dynBrake, motorPowerOn, holdRel, panelReadyMsg, panelStatus, operable, motorCmdValid;
    logic holdingBrakeApply, ready, status;
    logic [31:0] motorCmd;
    logic [31:0] expQ[$];
    int err_count = 0;
    int compares = 0;
    servo_link_if link();
    assign ready = link.driveReady;
    assign status = link.servoEnabledStatus;
    servo_enable_sequencer u_servo_enable_sequencer (.core_clk(core_clk), .rst(rst), .link(link),
        .cpuInitDone(cpuInitDone), .mainPowerOn(mainPowerOn), .alarmActive(alarmActive),
        .directionInvertParam(dirParam), .dynamicBrakeActive(dynBrake), .motorPowerOn(motorPowerOn),
        .holdingBrakeRelease(holdRel), .panelReadyMsg(panelReadyMsg),
        .panelStatusDisplay(panelStatus), .operable(operable), .motorCmd(motorCmd),
        .motorCmdValid(motorCmdValid));
    servo_host_ctrl u_servo_host_ctrl (.core_clk(core_clk), .rst(rst), .link(link),
        .userEnable(userEnable), .userJogStart(1'h0), .userCmdValid(userCmdValid),
        .userCmd(userCmd), .userPolarity(userPolarity), .holdingBrakeApply(holdingBrakeApply),
        .jogAllowed(), .cmdTaken());
    servo_link_properties u_props (.core_clk(core_clk), .rst(rst),
        .servoEnableRequest(link.servoEnableRequest), .cmdValid(link.cmdValid),
        .driveReady(link.driveReady), .servoEnabledStatus(link.servoEnabledStatus),
        .cmdAccept(link.cmdAccept), .motorMoving(link.motorMoving));

    // The clock toggles every half period of 100 ns.
    always #50 core_clk = ~core_clk;

    // Signed negation stands for a reversed direction of rotation.
    function automatic logic [31:0] exp_cmd(input logic [31:0] v, input logic inv);
        return inv ? -v : v;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_lv(input string what, ref logic s, input logic lv, input int lim);
        int n;
        n = 0;
        while (s !== lv && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        check(what, lv, s);
    endtask

    task automatic final_report();
        $display("Compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Every command out of the drive is matched in order; the step order is watched throughout.
    always @(posedge core_clk) begin
        if (!rst && motorCmdValid === 1'h1) begin
            check("motorCmd", expQ.size() > 0 ? expQ.pop_front() : 32'h0, motorCmd);
        end
        if ((holdRel === 1'h1 && motorPowerOn !== 1'h1) || (motorPowerOn === 1'h1 && dynBrake !== 1'h0)
            || (status === 1'h1 && holdRel !== 1'h1)) begin
            check("stepOrder", 1, 0);
        end
        if (holdingBrakeApply === 1'h1 && link.motorMoving === 1'h1) begin
            check("brakeWhileMoving", 0, 1);
        end
    end

    // The direction parameter is latched after reset only, so each setting gets its own pass.
    task automatic run_pass(input logic d);
        logic [31:0] v;
        logic ok;
        logic p;
        @(posedge core_clk);
        rst <= 1'h1;
        dirParam <= d;
        cpuInitDone <= 1'h0;
        mainPowerOn <= 1'h0;
        repeat (2) @(posedge core_clk);
        check("panelReadyMsg", 1, panelReadyMsg);
        check("dynBrake", 1, dynBrake);
        rst <= 1'h0;
        cpuInitDone <= 1'h1;
        repeat (8) @(posedge core_clk);
        check("readyNoPower", 0, ready);
        mainPowerOn <= 1'h1;
        wait_lv("driveReady", ready, 1'h1, 8);
        check("operable", 1, operable);
        // The panel memory registers one edge after ready, so the view switches a cycle later.
        @(posedge core_clk);
        check("panelStatus", 1, panelStatus);
        userEnable <= 1'h1;
        wait_lv("status", status, 1'h1, 50);
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 40; i++) begin
            v = (i == 0) ? 32'h8000_0000 : $urandom();
            p = 1'($urandom_range(1, 0));
            ok = ($urandom_range(3, 0) != 0);
            userCmdValid <= ok;
            userCmd <= v;
            userPolarity <= p;
            if (ok) expQ.push_back(exp_cmd(v, d | p));
            @(posedge core_clk);
        end
        userCmdValid <= 1'h0;
        repeat (4) @(posedge core_clk);
        check("pending", 0, expQ.size());
        userEnable <= 1'h0;
        wait_lv("statusOff", status, 1'h0, 100);
        check("brakeBack", 1, dynBrake);
        alarmActive <= 1'h1;
        wait_lv("readyAlarm", ready, 1'h0, 6);
        check("alarmOperable", 0, operable);
        alarmActive <= 1'h0;
    endtask

    // Both direction settings run, then the verdict is printed.
    initial begin
        void'($urandom(64));
        run_pass(1'h0);
        run_pass(1'h1);
        final_report();
    end

    // A hang is cut short well beyond the expected few hundred cycles.
    initial begin
        repeat (2000) @(posedge core_clk);
        err_count++;
        final_report();
    end
endmodule // servo_enable_sequencer_bench
